// >>> hdl/gpma_pkg.sv
// Constants, carrier types and timing figures for the gigabit
// copper attachment-layer role control block.
// Assumes a single 10 MHz clock; all counts derive from its period.
package gpma_pkg;

	// Quinary symbol width, signed -2..+2
	localparam int SYMB_W = 3;
	// Pair count on the copper medium
	localparam int NUM_PAIRS = 4;
	// Random seed width
	localparam int SEED_W = 11;
	// Seed attempt limit before a fault
	localparam logic [2:0] SEED_LIMIT = 3'h7;
	// Seed counter clear value
	localparam logic [2:0] SEED_ZERO = 3'h0;
	// Zero symbol on a pair
	localparam logic [SYMB_W-1:0] SYMB_ZERO = 3'h0;

	// Clock period and unit scales
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned NS_PER_MS = 1000000;
	localparam int unsigned NS_PER_US = 1000;

	// Timer figures in their own units
	localparam int unsigned XOVER_TOGGLE_MS = 1300;
	localparam int unsigned MAXWAIT_MASTER_MS = 750;
	localparam int unsigned MAXWAIT_SLAVE_MS = 350;
	localparam int unsigned XOVER_SAMPLE_MS = 62;
	localparam int unsigned MINWAIT_US = 1;
	localparam int unsigned STABILIZE_US = 1;

	// Cycle counts; nominal figure sits mid tolerance
	localparam int unsigned XOVER_TOGGLE_CYC =
		XOVER_TOGGLE_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned MAXWAIT_MASTER_CYC =
		MAXWAIT_MASTER_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned MAXWAIT_SLAVE_CYC =
		MAXWAIT_SLAVE_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned XOVER_SAMPLE_CYC =
		XOVER_SAMPLE_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned MINWAIT_CYC =
		MINWAIT_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int unsigned STABILIZE_CYC =
		STABILIZE_US * NS_PER_US / CLK_PERIOD_NS;

	// Timer counter width, covers 1.3 s
	localparam int TMR_W = 24;

	// Four pair symbols, index 0 is pair A
	typedef logic [NUM_PAIRS-1:0][SYMB_W-1:0] gpma_quad_t;

	// One end's forced-role configuration
	typedef struct packed {
		logic manual;
		logic want_master;
	} gpma_ms_cfg_t;

	// Resolved role value
	typedef enum logic {
		GPMA_SLAVE = 1'b0,
		GPMA_MASTER = 1'b1
	} gpma_role_t;

	// Crossover state value
	typedef enum logic {
		GPMA_STRAIGHT = 1'b0,
		GPMA_CROSSED = 1'b1
	} gpma_xover_t;

	// Transmit pattern select
	typedef enum logic [1:0] {
		GPMA_SEND_Z = 2'b00,
		GPMA_SEND_I = 2'b01,
		GPMA_SEND_N = 2'b10
	} gpma_tx_mode_t;

	// Kind of page seen in the exchange
	typedef enum logic [1:0] {
		GPMA_PG_BASE = 2'b00,
		GPMA_PG_FMT = 2'b01,
		GPMA_PG_UNF = 2'b10
	} gpma_page_t;

	// Page position holding the last unformatted page
	localparam logic [1:0] PAGE_LAST_IDX = 2'h3;
	localparam logic [1:0] PAGE_FIRST_UNF = 2'h2;

	// Resolution states
	typedef enum logic [2:0] {
		GPMA_ST_IDLE = 3'b000,
		GPMA_ST_PAGES = 3'b001,
		GPMA_ST_RESOLVE = 3'b010,
		GPMA_ST_SEED = 3'b011,
		GPMA_ST_DONE = 3'b100
	} gpma_state_t;

endpackage

// >>> hdl/gpma_timer.sv
// Restartable down-counting timer, one-shot or periodic.
// Assumes start, clear and enable come from the same clock domain.
`timescale 1ns/1ps

module gpma_timer import gpma_pkg::*; #(
	parameter int W = TMR_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic clr,
	input wire logic start,
	input wire logic periodic,
	input wire logic [W-1:0] terminal,
	output logic expired,
	output logic running
);

	logic [W-1:0] cnt_q, cnt_d; // Cycles left
	logic run_q, run_d; // Counting
	logic exp_q, exp_d; // Expiry pulse

	// Next count; clear wins, otherwise start reloads, even mid count
	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		exp_d = 1'b0;
		if (clr) begin
			cnt_d = '0;
			run_d = 1'b0;
		end else if (start) begin
			cnt_d = terminal - W'(1);
			run_d = 1'b1;
		end else if (run_q) begin
			if (cnt_q == '0) begin
				// Terminal reached
				exp_d = 1'b1;
				run_d = periodic;
				cnt_d = terminal - W'(1);
			end else begin
				cnt_d = cnt_q - W'(1);
			end
		end
	end

	// Registers, frozen while enable is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			exp_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			exp_q <= exp_d;
		end
	end

	assign expired = exp_q;
	assign running = run_q;

endmodule

// >>> hdl/gpma_core.sv
// Attachment-layer control: symbol launch, receive capture,
// crossover state, control timers and role resolution.
// Assumes symbol ticks are strobes; recovered tick and receive
// lines arrive from outside the clock domain.
`timescale 1ns/1ps

module gpma_core import gpma_pkg::*; #(
	parameter bit AUTO_XOVER_EN = 1'b1,
	parameter int unsigned TOGGLE_CYC = XOVER_TOGGLE_CYC,
	parameter int unsigned MAXW_M_CYC = MAXWAIT_MASTER_CYC,
	parameter int unsigned MAXW_S_CYC = MAXWAIT_SLAVE_CYC,
	parameter int unsigned SAMPLE_CYC = XOVER_SAMPLE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic mgmt_reset_req,
	input wire logic ctrl_reset_req,
	output logic reset_active,
	input wire logic local_symbol_tick,
	input wire logic recovered_symbol_tick,
	output logic symbol_transmit_clock,
	input wire gpma_tx_mode_t tx_mode,
	input wire gpma_quad_t tx_symb_vector,
	input wire gpma_quad_t idle_symb_vector,
	output logic [SYMB_W-1:0] pair_a_line,
	output logic [SYMB_W-1:0] pair_b_line,
	output logic [SYMB_W-1:0] pair_c_line,
	output logic [SYMB_W-1:0] pair_d_line,
	input wire gpma_quad_t rx_pair_lines,
	output gpma_quad_t rx_symb_vector,
	output logic rx_symb_valid,
	input wire logic energy_detect,
	output logic link_det,
	output gpma_xover_t crossover_state,
	input wire logic maxwait_start,
	output logic maxwait_done,
	input wire logic minwait_start,
	output logic minwait_done,
	input wire logic stabilize_start,
	output logic stabilize_done,
	input wire logic an_restart,
	input wire logic page_strobe,
	input wire gpma_page_t page_kind,
	input wire gpma_ms_cfg_t local_cfg,
	input wire gpma_ms_cfg_t partner_cfg,
	input wire logic [SEED_W-1:0] local_seed,
	input wire logic [SEED_W-1:0] partner_seed,
	output logic new_seed_req,
	input wire logic seed_sent,
	output gpma_role_t role_indication,
	output logic resolution_done,
	output logic resolution_fault,
	output logic [2:0] seed_count,
	input wire logic link_monitor_ok,
	output logic gigabit_link_state
);

	// Soft reset from management or control
	logic soft_rst;
	assign soft_rst = mgmt_reset_req | ctrl_reset_req;

	// Reset indication register
	logic rstact_q, rstact_d;
	always_comb begin
		rstact_d = soft_rst;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rstact_q <= 1'b1;
		end else if (ce) begin
			rstact_q <= rstact_d;
		end
	end
	assign reset_active = rstact_q;

	// Recovered tick synchroniser; stage one feeds stage two only
	logic [2:0] rtick_q;
	logic rtick_seen_q, rtick_seen_d; // Agreed level
	logic rtick_evt; // Agreed rising edge
	always_comb begin
		rtick_seen_d = rtick_seen_q;
		if (rtick_q[1] == rtick_q[2]) begin
			rtick_seen_d = rtick_q[2];
		end
	end
	assign rtick_evt = rtick_seen_d & ~rtick_seen_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rtick_q <= 3'h0;
			rtick_seen_q <= 1'b0;
		end else if (ce) begin
			rtick_q <= {rtick_q[1:0], recovered_symbol_tick};
			rtick_seen_q <= rtick_seen_d;
		end
	end

	// Resolved role register, read by clock selection
	gpma_role_t role_q, role_d;

	logic sym_tick;
	assign sym_tick = (role_q == GPMA_MASTER) ? local_symbol_tick
		: rtick_evt;

	// Transmit symbol registers, one per pair
	gpma_quad_t txq_q, txq_d;
	logic stclk_q, stclk_d;

	// Pattern mux; zero pattern keeps the line quiet
	always_comb begin
		txq_d = txq_q;
		stclk_d = 1'b0;
		if (soft_rst) begin
			txq_d = '0;
		end else if (sym_tick) begin
			stclk_d = 1'b1;
			case (tx_mode)
				GPMA_SEND_N: txq_d = tx_symb_vector;
				GPMA_SEND_I: txq_d = idle_symb_vector;
				GPMA_SEND_Z: txq_d = '0;
				default: txq_d = '0;
			endcase
		end
	end

	// Transmit registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txq_q <= '0;
			stclk_q <= 1'b0;
		end else if (ce) begin
			txq_q <= txq_d;
			stclk_q <= stclk_d;
		end
	end

	assign pair_a_line = txq_q[0];
	assign pair_b_line = txq_q[1];
	assign pair_c_line = txq_q[2];
	assign pair_d_line = txq_q[3];
	assign symbol_transmit_clock = stclk_q;

	// Receive line synchronisers, one per pair
	gpma_quad_t rx_agree; // Agreed value per pair
	gpma_quad_t rx_s1_q, rx_s2_q, rx_s3_q;
	gpma_quad_t rx_hold_q;
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_rx
			// Keep old value until stages two and three agree
			always_comb begin
				rx_agree[gp] = rx_hold_q[gp];
				if (rx_s2_q[gp] == rx_s3_q[gp]) begin
					rx_agree[gp] = rx_s3_q[gp];
				end
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					rx_s1_q[gp] <= SYMB_ZERO;
					rx_s2_q[gp] <= SYMB_ZERO;
					rx_s3_q[gp] <= SYMB_ZERO;
					rx_hold_q[gp] <= SYMB_ZERO;
				end else if (ce) begin
					rx_s1_q[gp] <= rx_pair_lines[gp];
					rx_s2_q[gp] <= rx_s1_q[gp];
					rx_s3_q[gp] <= rx_s2_q[gp];
					rx_hold_q[gp] <= rx_agree[gp];
				end
			end
		end
	endgenerate

	// One vector per recovered symbol period
	gpma_quad_t rxv_q, rxv_d;
	logic rxval_q, rxval_d;
	always_comb begin
		rxv_d = rxv_q;
		rxval_d = 1'b0;
		if (soft_rst) begin
			rxv_d = '0;
		end else if (rtick_evt) begin
			rxv_d = rx_agree;
			rxval_d = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxv_q <= '0;
			rxval_q <= 1'b0;
		end else if (ce) begin
			rxv_q <= rxv_d;
			rxval_q <= rxval_d;
		end
	end
	assign rx_symb_vector = rxv_q;
	assign rx_symb_valid = rxval_q;

	// Control timers
	logic toggle_exp, sample_exp;
	logic [TMR_W-1:0] maxw_term;
	assign maxw_term = (role_q == GPMA_MASTER) ? TMR_W'(MAXW_M_CYC)
		: TMR_W'(MAXW_S_CYC);

	logic tog_run, smp_run; // Periodic timers free-run after reset

	gpma_timer #(.W(TMR_W)) u_toggle (.clk(clk), .rst(rst), .ce(ce),
		.clr(soft_rst), .start(~rstact_q & ~tog_run),
		.periodic(1'b1), .terminal(TMR_W'(TOGGLE_CYC)),
		.expired(toggle_exp), .running(tog_run));
	gpma_timer #(.W(TMR_W)) u_sample (.clk(clk), .rst(rst), .ce(ce),
		.clr(soft_rst), .start(~rstact_q & ~smp_run),
		.periodic(1'b1), .terminal(TMR_W'(SAMPLE_CYC)),
		.expired(sample_exp), .running(smp_run));
	gpma_timer #(.W(TMR_W)) u_maxwait (.clk(clk), .rst(rst), .ce(ce),
		.clr(soft_rst), .start(maxwait_start), .periodic(1'b0),
		.terminal(maxw_term), .expired(maxwait_done),
		.running());
	gpma_timer #(.W(TMR_W)) u_minwait (.clk(clk), .rst(rst), .ce(ce),
		.clr(soft_rst), .start(minwait_start), .periodic(1'b0),
		.terminal(TMR_W'(MINWAIT_CYC)), .expired(minwait_done),
		.running());
	gpma_timer #(.W(TMR_W)) u_stab (.clk(clk), .rst(rst), .ce(ce),
		.clr(soft_rst), .start(stabilize_start), .periodic(1'b0),
		.terminal(TMR_W'(STABILIZE_CYC)), .expired(stabilize_done),
		.running());

	// Energy detect synchroniser
	logic [2:0] en_q;
	logic en_lvl_q, en_lvl_d;
	always_comb begin
		en_lvl_d = en_lvl_q;
		if (en_q[1] == en_q[2]) begin
			en_lvl_d = en_q[2];
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en_q <= 3'h0;
			en_lvl_q <= 1'b0;
		end else if (ce) begin
			en_q <= {en_q[1:0], energy_detect};
			en_lvl_q <= en_lvl_d;
		end
	end

	logic ldet_q, ldet_d;
	gpma_xover_t xo_q, xo_d;
	always_comb begin
		ldet_d = ldet_q;
		xo_d = xo_q;
		if (soft_rst || !AUTO_XOVER_EN) begin
			ldet_d = 1'b0;
			xo_d = GPMA_STRAIGHT;
		end else begin
			// Sample link presence each sample period
			if (sample_exp) begin
				ldet_d = en_lvl_q;
			end
			// Hunt only while nothing is detected
			if (toggle_exp && !ldet_q) begin
				xo_d = (xo_q == GPMA_STRAIGHT) ? GPMA_CROSSED
					: GPMA_STRAIGHT;
			end
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ldet_q <= 1'b0;
			xo_q <= GPMA_STRAIGHT;
		end else if (ce) begin
			ldet_q <= ldet_d;
			xo_q <= xo_d;
		end
	end
	assign link_det = ldet_q;
	assign crossover_state = xo_q;

	// Role resolution state
	gpma_state_t st_q, st_d;
	logic [1:0] pg_q, pg_d; // Next page position
	logic [2:0] seed_q, seed_d;
	logic fault_q, fault_d;
	logic done_q, done_d;
	logic nsr_q, nsr_d;
	gpma_page_t pg_want; // Kind expected at this position

	always_comb begin
		case (pg_q)
			2'h0: pg_want = GPMA_PG_BASE;
			2'h1: pg_want = GPMA_PG_FMT;
			default: pg_want = GPMA_PG_UNF;
		endcase
	end

	// Next resolution state
	always_comb begin
		st_d = st_q;
		pg_d = pg_q;
		seed_d = seed_q;
		fault_d = fault_q;
		done_d = done_q;
		role_d = role_q;
		nsr_d = 1'b0;
		if (soft_rst) begin
			st_d = GPMA_ST_IDLE;
			pg_d = 2'h0;
			seed_d = SEED_ZERO;
			fault_d = 1'b0;
			done_d = 1'b0;
			role_d = GPMA_SLAVE;
		end else if (an_restart) begin
			st_d = GPMA_ST_PAGES;
			pg_d = 2'h0;
			done_d = 1'b0;
		end else begin
			case (st_q)
				GPMA_ST_IDLE: begin
					st_d = GPMA_ST_IDLE;
				end
				GPMA_ST_PAGES: begin
					if (page_strobe) begin
						// Wrong order breaks sequence; restart
						if (page_kind != pg_want) begin
							pg_d = 2'h0;
						end else if (pg_q == PAGE_LAST_IDX) begin
							pg_d = 2'h0;
							st_d = GPMA_ST_RESOLVE;
						end else begin
							pg_d = pg_q + 2'h1;
						end
					end
				end
				GPMA_ST_RESOLVE: begin
					st_d = GPMA_ST_DONE;
					done_d = 1'b1;
					seed_d = SEED_ZERO;
					fault_d = 1'b0;
					if (local_cfg.manual && partner_cfg.manual &&
						local_cfg.want_master ==
						partner_cfg.want_master) begin
						fault_d = 1'b1;
					end else if (local_cfg.manual) begin
						role_d = gpma_role_t'(local_cfg.want_master);
					end else if (partner_cfg.manual) begin
						role_d = gpma_role_t'(~partner_cfg.want_master);
					end else if (local_seed > partner_seed) begin
						role_d = GPMA_MASTER;
					end else if (local_seed < partner_seed) begin
						role_d = GPMA_SLAVE;
					end else if (seed_q == SEED_LIMIT) begin
						fault_d = 1'b1;
					end else begin
						// Tie: ask for a new seed
						st_d = GPMA_ST_SEED;
						done_d = 1'b0;
						seed_d = seed_q;
						fault_d = fault_q;
						nsr_d = 1'b1;
					end
				end
				GPMA_ST_SEED: begin
					nsr_d = ~seed_sent;
					if (seed_sent) begin
						seed_d = seed_q + 3'h1;
						st_d = GPMA_ST_PAGES;
					end
				end
				GPMA_ST_DONE: begin
					st_d = GPMA_ST_DONE;
				end
				default: begin
					st_d = GPMA_ST_IDLE;
				end
			endcase
		end
	end

	// Resolution registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= GPMA_ST_IDLE;
			pg_q <= 2'h0;
			seed_q <= SEED_ZERO;
			fault_q <= 1'b0;
			done_q <= 1'b0;
			role_q <= GPMA_SLAVE;
			nsr_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			pg_q <= pg_d;
			seed_q <= seed_d;
			fault_q <= fault_d;
			done_q <= done_d;
			role_q <= role_d;
			nsr_q <= nsr_d;
		end
	end

	assign role_indication = role_q;
	assign new_seed_req = nsr_q;
	assign seed_count = seed_q;
	assign resolution_fault = fault_q;
	assign resolution_done = done_q;
	assign gigabit_link_state = link_monitor_ok & done_q & ~fault_q;

endmodule

// >>> bench/gpma_core_properties.sv
// Port checker for the role control core, bound from below.
// Assumes one clock domain with the asynchronous reset rst.
`timescale 1ns/1ps

module gpma_core_properties import gpma_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic mgmt_reset_req,
	input wire logic ctrl_reset_req,
	input wire logic reset_active,
	input wire logic local_symbol_tick,
	input wire logic symbol_transmit_clock,
	input wire gpma_tx_mode_t tx_mode,
	input wire gpma_quad_t tx_symb_vector,
	input wire logic [SYMB_W-1:0] pair_a_line,
	input wire logic [SYMB_W-1:0] pair_b_line,
	input wire logic [SYMB_W-1:0] pair_c_line,
	input wire logic [SYMB_W-1:0] pair_d_line,
	input wire logic rx_symb_valid,
	input wire logic minwait_start,
	input wire logic minwait_done,
	input wire logic stabilize_start,
	input wire logic stabilize_done,
	input wire logic seed_sent,
	input wire logic new_seed_req,
	input wire gpma_role_t role_indication,
	input wire logic resolution_done,
	input wire logic resolution_fault,
	input wire logic [2:0] seed_count,
	input wire logic gigabit_link_state
);
	// All pair lines as one vector, pair A lowest
	gpma_quad_t tx_lines;
	assign tx_lines = {pair_d_line, pair_c_line, pair_b_line, pair_a_line};

	// One domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_soft;
		(mgmt_reset_req || ctrl_reset_req) && ce |=> reset_active &&
			role_indication == GPMA_SLAVE && seed_count == SEED_ZERO;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset");
	property p_mtick;
		local_symbol_tick && role_indication == GPMA_MASTER && ce &&
			!mgmt_reset_req && !ctrl_reset_req |=> symbol_transmit_clock;
	endproperty
	a_mtick: assert property (p_mtick) else $error("local tick");
	property p_data;
		symbol_transmit_clock && $past(tx_mode) == GPMA_SEND_N
			|-> tx_lines == $past(tx_symb_vector);
	endproperty
	a_data: assert property (p_data) else $error("data lines");
	property p_zero;
		symbol_transmit_clock && $past(tx_mode) inside {GPMA_SEND_Z, 2'h3}
			|-> tx_lines == 12'h000;
	endproperty
	a_zero: assert property (p_zero) else $error("zero lines");
	// Valid is one pulse per symbol
	property p_rxv;
		rx_symb_valid |=> !rx_symb_valid;
	endproperty
	a_rxv: assert property (p_rxv) else $error("rx valid");
	// Window of 0.9 to 1.1 us plus the registered pulse
	property p_minw;
		minwait_start |=> !minwait_done [*8] ##[1:4] minwait_done;
	endproperty
	a_minw: assert property (p_minw) else $error("minwait");
	property p_stab;
		stabilize_start |=> !stabilize_done [*8] ##[1:4] stabilize_done;
	endproperty
	a_stab: assert property (p_stab) else $error("stabilize");
	property p_seed;
		seed_sent && new_seed_req |=> seed_count == $past(seed_count) + 3'h1;
	endproperty
	a_seed: assert property (p_seed) else $error("seed step");
	property p_done;
		$rose(resolution_done) |-> seed_count == SEED_ZERO;
	endproperty
	a_done: assert property (p_done) else $error("seed clear");
	// Fault bit stays up through a restart, so completion is checked
	// where it rises
	property p_fault;
		$rose(resolution_fault) |-> resolution_done && !gigabit_link_state;
	endproperty
	a_fault: assert property (p_fault) else $error("fault link");
	property p_fail;
		resolution_fault |-> !gigabit_link_state;
	endproperty
	a_fail: assert property (p_fail) else $error("fault fail");
	c_fault: cover property ($rose(resolution_fault));
	c_seed: cover property (seed_sent && new_seed_req);
	c_tick: cover property (symbol_transmit_clock && rx_symb_valid == 1'b0);
endmodule

bind gpma_core gpma_core_properties i_gpma_core_properties (.clk, .rst,
	.ce, .mgmt_reset_req, .ctrl_reset_req, .reset_active, .local_symbol_tick,
	.symbol_transmit_clock, .tx_mode, .tx_symb_vector, .pair_a_line,
	.pair_b_line, .pair_c_line, .pair_d_line, .rx_symb_valid, .minwait_start,
	.minwait_done, .stabilize_start, .stabilize_done, .seed_sent,
	.new_seed_req, .role_indication, .resolution_done, .resolution_fault,
	.seed_count, .gigabit_link_state);

// >>> bench/gpma_partner.sv
// Behavioural link partner: pages, seed, recovered clock, lines.
// Assumes the bench sets its knobs off the rising edge.
`timescale 1ns/1ps

module gpma_partner import gpma_pkg::*; (
	input wire logic clk,
	input wire logic an_restart,
	input wire logic seed_sent,
	input wire logic run,
	input wire logic e_on,
	input wire gpma_quad_t rxv,
	input wire logic [SEED_W-1:0] ps,
	input wire gpma_ms_cfg_t pc,
	output logic recovered_symbol_tick,
	output gpma_quad_t rx_pair_lines,
	output logic energy_detect,
	output logic page_strobe,
	output gpma_page_t page_kind,
	output logic [SEED_W-1:0] partner_seed,
	output gpma_ms_cfg_t partner_cfg
);
	logic [2:0] pos_q; // Page position, 0 idle
	logic [2:0] div_q; // Recovered clock divider
	initial begin
		pos_q = 3'h0;
		div_q = 3'h0;
	end
	// base, formatted, two unformatted, back to back
	always @(posedge clk) begin
		if (an_restart || seed_sent) begin
			pos_q <= 3'h1;
		end else begin
			pos_q <= (pos_q == 3'h4 || pos_q == 3'h0) ? 3'h0 : pos_q + 3'h1;
		end
	end
	assign page_strobe = (pos_q != 3'h0);
	assign page_kind = (pos_q == 3'h1) ? GPMA_PG_BASE :
		(pos_q == 3'h2) ? GPMA_PG_FMT : GPMA_PG_UNF;
	// Clock stands low between bursts, period 8 cycles
	always @(posedge clk) begin
		div_q <= run ? div_q + 3'h1 : 3'h0;
	end
	assign recovered_symbol_tick = div_q[2];
	// Idle lines show the inverse, never a stale copy
	assign rx_pair_lines = run ? rxv : ~rxv;
	assign energy_detect = e_on;
	// seed and forced role offered to resolution
	assign partner_seed = ps;
	assign partner_cfg = pc;
endmodule

// >>> bench/gpma_core_bench.sv
// Self-checking bench for the role control core and its partner.
// Assumes the checker binds itself; inputs change on falling edges.
`timescale 1ns/1ps

module gpma_core_bench import gpma_pkg::*;;
	localparam int TG = 50; // Shortened toggle period
	localparam int MM = 40; // Shortened master wait
	localparam int MS = 30; // Shortened slave wait
	localparam int SM = 20; // Shortened sample period
	logic clk, rst, ce, mgmt_reset_req, ctrl_reset_req, reset_active;
	logic local_symbol_tick, recovered_symbol_tick, symbol_transmit_clock;
	logic rx_symb_valid, energy_detect, link_det, maxwait_start;
	logic maxwait_done, minwait_start, minwait_done, stabilize_start;
	logic stabilize_done, an_restart, page_strobe, new_seed_req, seed_sent;
	logic resolution_done, resolution_fault, link_monitor_ok;
	logic gigabit_link_state, run, e_on, s;
	logic [SYMB_W-1:0] pair_a_line, pair_b_line, pair_c_line, pair_d_line;
	logic [SEED_W-1:0] local_seed, partner_seed, p_seed;
	logic [2:0] seed_count, dn;
	gpma_tx_mode_t tx_mode;
	gpma_quad_t tx_symb_vector, idle_symb_vector, rx_pair_lines;
	gpma_quad_t rx_symb_vector, rx_v;
	gpma_xover_t crossover_state, xs;
	gpma_page_t page_kind;
	gpma_ms_cfg_t local_cfg, partner_cfg, p_cfg;
	gpma_role_t role_indication;
	int bad_count, checks_done, n;
	assign dn = {maxwait_done, stabilize_done, minwait_done};

	gpma_core #(.TOGGLE_CYC(TG), .MAXW_M_CYC(MM), .MAXW_S_CYC(MS),
		.SAMPLE_CYC(SM)) i_gpma_core (.clk, .rst, .ce, .mgmt_reset_req,
		.ctrl_reset_req, .reset_active, .local_symbol_tick,
		.recovered_symbol_tick, .symbol_transmit_clock, .tx_mode,
		.tx_symb_vector, .idle_symb_vector, .pair_a_line, .pair_b_line,
		.pair_c_line, .pair_d_line, .rx_pair_lines, .rx_symb_vector,
		.rx_symb_valid, .energy_detect, .link_det, .crossover_state,
		.maxwait_start, .maxwait_done, .minwait_start, .minwait_done,
		.stabilize_start, .stabilize_done, .an_restart, .page_strobe,
		.page_kind, .local_cfg, .partner_cfg, .local_seed, .partner_seed,
		.new_seed_req, .seed_sent, .role_indication, .resolution_done,
		.resolution_fault, .seed_count, .link_monitor_ok,
		.gigabit_link_state);
	gpma_partner i_gpma_partner (.clk, .an_restart, .seed_sent, .run, .e_on,
		.rxv(rx_v), .ps(p_seed), .pc(p_cfg), .recovered_symbol_tick,
		.rx_pair_lines, .energy_detect, .page_strobe, .page_kind,
		.partner_seed, .partner_cfg);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [11:0] sv, ev);
		checks_done++;
		if (sv !== ev) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, ev, sv);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// A used-up wait bound counts as a mismatch and ends the run
	task automatic lim(input int k, input int b);
		if (k >= b) begin
			bad_count++;
			end_of_test();
		end
	endtask
	// One local tick; lines land the cycle after
	task automatic tx(input logic [1:0] m, input gpma_quad_t e);
		tx_mode = gpma_tx_mode_t'(m);
		local_symbol_tick = 1'b1;
		cyc(1);
		local_symbol_tick = 1'b0;
		chk("strobe", 12'(symbol_transmit_clock), 12'h001);
		chk("lines", {pair_d_line, pair_c_line, pair_b_line, pair_a_line}, e);
		cyc(1);
	endtask
	// Restart negotiation; partner sends pages, result by cycle 6
	task automatic res(input logic [10:0] ls, ps, input logic [1:0] lc, pc);
		local_seed = ls;
		p_seed = ps;
		local_cfg = lc;
		p_cfg = pc;
		an_restart = 1'b1;
		cyc(1);
		an_restart = 1'b0;
		cyc(8);
	endtask
	// Answer a tie with a new seed, partner pages again
	task automatic resend(input logic [2:0] k);
		chk("seed_req", 12'(new_seed_req), 12'h001);
		seed_sent = 1'b1;
		cyc(1);
		seed_sent = 1'b0;
		chk("seed_cnt", 12'(seed_count), 12'(k));
		cyc(8);
	endtask
	// Start a timer, expiry must land in its window
	task automatic tw(input int k, input int t);
		{maxwait_start, stabilize_start, minwait_start} = 3'(1 << k);
		cyc(1);
		{maxwait_start, stabilize_start, minwait_start} = 3'h0;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (n < 200 && dn[k] !== 1'b1);
		lim(n, 200);
		chk("timer", 12'(n >= t - 1 && n <= t + 1), 12'h001);
	endtask
	// Cycles until the crossover state next changes
	task automatic xw();
		xs = crossover_state;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (n < 200 && crossover_state === xs);
		lim(n, 200);
	endtask

	initial begin
		{rst, ce, link_monitor_ok} = 3'h7;
		{mgmt_reset_req, ctrl_reset_req, local_symbol_tick} = 3'h0;
		{minwait_start, stabilize_start, maxwait_start} = 3'h0;
		{an_restart, seed_sent, run, e_on} = 4'h0;
		tx_mode = GPMA_SEND_N;
		tx_symb_vector = 12'hDD1;
		idle_symb_vector = 12'hE88;
		rx_v = 12'h056;
		local_seed = 11'h000;
		p_seed = 11'h000;
		local_cfg = 2'h0;
		p_cfg = 2'h0;
		cyc(16);
		chk("rst", 12'({reset_active, role_indication, seed_count}),
			12'h010);
		rst = 1'b0;
		cyc(2);
		// Same forced role at both ends, both roles
		for (int m = 0; m < 2; m++) begin
			res(11'h100, 11'h100, {1'b1, 1'(m)}, {1'b1, 1'(m)});
			chk("fault", 12'({resolution_fault, resolution_done,
				gigabit_link_state}), 12'h006);
		end
		// Tie, new seed, then the local end wins
		res(11'h055, 11'h055, 2'h0, 2'h0);
		local_seed = 11'h3FF;
		resend(3'h1);
		chk("done", 12'({resolution_fault, seed_count, gigabit_link_state}),
			12'h001);
		chk("role", 12'(role_indication), 12'(GPMA_MASTER));
		tx(2'h2, tx_symb_vector);
		tx(2'h1, idle_symb_vector);
		tx(2'h0, 12'h000);
		tx(2'h3, 12'h000);
		tw(0, MINWAIT_CYC);
		tw(1, STABILIZE_CYC);
		tw(2, MM);
		// Both soft requests, the first while MASTER
		for (int k = 1; k < 3; k++) begin
			{ctrl_reset_req, mgmt_reset_req} = 2'(k);
			cyc(1);
			{ctrl_reset_req, mgmt_reset_req} = 2'h0;
			chk("soft", 12'({reset_active, role_indication}), 12'h002);
			cyc(2);
		end
		// Lower local seed: SLAVE, recovered clock times symbols
		res(11'h010, 11'h200, 2'h0, 2'h0);
		chk("role", 12'(role_indication), 12'(GPMA_SLAVE));
		tw(2, MS);
		tx_mode = GPMA_SEND_N;
		tx_symb_vector = 12'h232;
		local_symbol_tick = 1'b1;
		cyc(1);
		local_symbol_tick = 1'b0;
		s = 1'b0;
		repeat (6) begin
			cyc(1);
			s = s | symbol_transmit_clock;
		end
		chk("slv_tick", 12'(s), 12'h000);
		run = 1'b1;
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (n < 60 && symbol_transmit_clock !== 1'b1);
		lim(n, 60);
		chk("slv_lines", {pair_d_line, pair_c_line, pair_b_line,
			pair_a_line}, 12'h232);
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (n < 60 && rx_symb_valid !== 1'b1);
		lim(n, 60);
		chk("rx", rx_symb_vector, rx_v);
		run = 1'b0;
		// Eight ties in a row, seven new seeds, end in a fault
		res(11'h077, 11'h077, 2'h0, 2'h0);
		for (int i = 1; i < 8; i++) begin
			resend(3'(i));
		end
		chk("seed_fault", 12'({resolution_fault, seed_count,
			gigabit_link_state}), 12'h010);
		// No link: state flips once per toggle period
		xw();
		xw();
		chk("toggle", 12'(n >= TG - 1 && n <= TG + 2), 12'h001);
		e_on = 1'b1;
		cyc(2 * SM + 10);
		chk("link_det", 12'(link_det), 12'h001);
		xs = crossover_state;
		// One full period: a free-running toggle would flip exactly once
		cyc(TG);
		chk("xover_hold", 12'(crossover_state), 12'(xs));
		end_of_test();
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
endmodule
